// >>> shared/fcs_consts.svh
// constants of the flash command sequencer
`ifndef FCS_CONSTS_SVH
`define FCS_CONSTS_SVH

// unlock addresses, low 16 address bits of the flash window
`define FCS_ADDR_LO_W   16
`define FCS_ADDR_A      16'h5400
`define FCS_ADDR_B      16'haa00

// command data words
`define FCS_D_UNLOCK1   32'h0000_00aa
`define FCS_D_UNLOCK2   32'h0000_0055
`define FCS_CMD_READ    32'h0000_00f0
`define FCS_CMD_ID      32'h0000_0090
`define FCS_CMD_PROG    32'h0000_00a0
`define FCS_CMD_ERASE   32'h0000_0080
`define FCS_CMD_CHIP    32'h0000_0010
`define FCS_CMD_BLOCK   32'h0000_0030
// protection: data[31:4] selects, data[3:0] is the code
`define FCS_CMD_PROT_HI 28'h000_0006
`define FCS_PROT_LSB    4
`define FCS_PROT_W      4
`define FCS_PROT_RST    4'h0

// page program address step, one word
`define FCS_WORD_STEP   32'h0000_0004

`endif

// >>> shared/fcs_pkg.sv
// types of the flash command sequencer
package fcs_pkg;

	typedef enum logic [3:0] {
		S_READ,
		S_C1,
		S_C2,
		S_ID,
		S_PRG_TOP,
		S_PRG_DATA,
		S_PRG_WAIT,
		S_E3,
		S_E4,
		S_E5,
		S_ERS_WAIT,
		S_LOCK
	} fcs_state_t;

	typedef enum logic [1:0] {
		OP_NONE,
		OP_PROG,
		OP_CHIP,
		OP_BLOCK
	} fcs_op_t;

endpackage

// >>> rtl/fcs_prot_table.sv
// per-block protection code store
`timescale 1ns/1ps
`include "fcs_consts.svh"

module fcs_prot_table #(
	parameter int NUM_BLOCKS = 16,
	parameter int BLK_W      = 4
) (
	input  wire logic                  sys_clk,
	input  wire logic                  srst,
	input  wire logic                  prot_wr,
	input  wire logic [BLK_W-1:0]      prot_blk,
	input  wire logic [`FCS_PROT_W-1:0] prot_code,
	output logic      [NUM_BLOCKS-1:0] prot_vec
);

	typedef struct packed {
		logic [NUM_BLOCKS-1:0][`FCS_PROT_W-1:0] code;
	} fcs_prot_st_t;

	fcs_prot_st_t s_q;
	fcs_prot_st_t s_d;

	if (NUM_BLOCKS != (1 << BLK_W)) begin : g_bad_cfg
		$error("fcs_prot_table: NUM_BLOCKS must equal 2**BLK_W");
	end

	always_comb begin
		s_d = s_q;
		if (prot_wr) begin
			s_d.code[prot_blk] = prot_code;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// a nonzero code inhibits program and erase of its block
	for (genvar i = 0; i < NUM_BLOCKS; i++) begin : g_blk
		assign prot_vec[i] = (s_q.code[i] != `FCS_PROT_RST);
	end

endmodule

// >>> rtl/fcs_sequencer.sv
// flash command sequencer: bus write decode, modes, array launch
// Behaviour
// - no array data while automatic operation runs
// - automatic operation ends only on array done or fail
// - read mode after reset and normal completion
// - single 0xF0 word write returns read mode except during page entry, where it is taken as a program word, and in the wait and lock states, where it is ignored
// - read/reset returns after its third write
// - mismatching cycle abandons command to read or ID mode, where it began
// - read/reset cancels partial or wrong entry
// - ID mode held until read/reset or a program, erase or protection command
// - 4-bit code inhibits program/erase per block
// - chip erase and block erase offered
// - program done sets ready; until then new commands ignored
// - failed operation locks until hardware reset
`timescale 1ns/1ps
`include "fcs_consts.svh"

module fcs_sequencer import fcs_pkg::*; #(
	parameter int          NUM_BLOCKS = 16,
	parameter int          BLK_SHIFT  = 16,
	parameter int          PAGE_WORDS = 128,
	parameter logic [31:0] DEV_ID     = 32'h0000_5a5a // arbitrary value
) (
	input  wire logic        sys_clk,
	input  wire logic        srst,
	input  wire logic        bus_wr,
	input  wire logic        bus_wr_word,
	input  wire logic [31:0] bus_addr,
	input  wire logic [31:0] bus_wdata,
	input  wire logic        rd_req,
	input  wire logic [31:0] rd_addr,
	output logic             rd_ack,
	output logic             rd_refused,
	output logic      [31:0] rd_data,
	output logic             arr_rd_en,
	output logic      [31:0] arr_rd_addr,
	input  wire logic [31:0] arr_rdata,
	output logic             arr_start,
	output logic             arr_wr,
	output fcs_op_t          arr_op,
	output logic      [31:0] arr_addr,
	output logic      [31:0] arr_wdata,
	output logic [NUM_BLOCKS-1:0] arr_keep,
	input  wire logic        arr_done,
	input  wire logic        arr_fail,
	output logic             ready_busy_flag,
	output logic             fetch_ok
);

	localparam int BLK_W = $clog2(NUM_BLOCKS);
	localparam int CNT_W = $clog2(PAGE_WORDS);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(PAGE_WORDS - 1);

	if (NUM_BLOCKS < 2 || NUM_BLOCKS != (1 << BLK_W)
		|| PAGE_WORDS < 2 || BLK_SHIFT + BLK_W > 32) begin : g_bad_cfg
		$error("fcs_sequencer: unsupported parameter values");
	end

	typedef struct packed {
		fcs_state_t        st;
		logic              in_id;
		logic              rdy;
		logic              skip;
		logic [CNT_W-1:0]  cnt;
		logic              arr_start;
		logic              arr_wr;
		fcs_op_t           arr_op;
		logic [31:0]       arr_addr;
		logic [31:0]       arr_wdata;
		logic              prot_wr;
		logic [BLK_W-1:0]  prot_blk;
		logic [`FCS_PROT_W-1:0] prot_code;
		logic              rd_ack;
		logic              rd_refused;
		logic [31:0]       rd_data;
	} fcs_main_st_t;

	fcs_main_st_t s_q;
	fcs_main_st_t d;

	logic [NUM_BLOCKS-1:0] prot_vec;
	logic [BLK_W-1:0]      wr_blk;
	logic                  wr_w;
	logic                  at_a;
	logic                  at_b;
	logic                  is_read_cmd;
	logic                  wr_unlock1;
	logic                  wr_unlock2;
	fcs_state_t            ret_st;

	// narrow writes never form a command cycle
	assign wr_w = bus_wr && bus_wr_word;
	assign at_a = bus_addr[`FCS_ADDR_LO_W-1:0] == `FCS_ADDR_A;
	assign at_b = bus_addr[`FCS_ADDR_LO_W-1:0] == `FCS_ADDR_B;
	assign wr_blk = bus_addr[BLK_SHIFT +: BLK_W];
	assign is_read_cmd = wr_w && bus_wdata == `FCS_CMD_READ;
	assign wr_unlock1 = wr_w && at_a && bus_wdata == `FCS_D_UNLOCK1;
	assign wr_unlock2 = wr_w && at_b && bus_wdata == `FCS_D_UNLOCK2;
	// aborted entry goes back to where it began
	assign ret_st = s_q.in_id ? S_ID : S_READ;

	fcs_prot_table #(
		.NUM_BLOCKS (NUM_BLOCKS),
		.BLK_W      (BLK_W)
	) u_prot (
		.sys_clk   (sys_clk),
		.srst      (srst),
		.prot_wr   (s_q.prot_wr),
		.prot_blk  (s_q.prot_blk),
		.prot_code (s_q.prot_code),
		.prot_vec  (prot_vec)
	);

	// array reads only while not busy and not in ID mode
	assign arr_rd_en = rd_req && s_q.rdy && s_q.st != S_ID;
	assign arr_rd_addr = rd_addr;

	always_comb begin
		d = s_q;
		d.arr_start = 1'b0;
		d.arr_wr = 1'b0;
		d.prot_wr = 1'b0;
		d.rd_ack = rd_req;
		d.rd_refused = rd_req && !s_q.rdy;
		d.rd_data = '0;
		if (rd_req && s_q.rdy) begin
			d.rd_data = (s_q.st == S_ID) ? DEV_ID : arr_rdata;
		end
		case (s_q.st)
			S_READ, S_ID: begin
				if (wr_unlock1) begin
					d.st = S_C1;
				end else if (is_read_cmd) begin
					d.st = S_READ;
				end
			end
			S_C1, S_E3: begin
				if (bus_wr) begin
					if (s_q.st == S_C1 && wr_unlock2) begin
						d.st = S_C2;
					end else if (s_q.st == S_E3 && wr_unlock1) begin
						d.st = S_E4;
					end else if (is_read_cmd) begin
						d.st = S_READ;
					end else begin
						d.st = ret_st;
					end
				end
			end
			S_E4: begin
				if (bus_wr) begin
					if (wr_unlock2) begin
						d.st = S_E5;
					end else if (is_read_cmd) begin
						d.st = S_READ;
					end else begin
						d.st = ret_st;
					end
				end
			end
			S_C2: begin
				if (bus_wr) begin
					d.st = ret_st;
					if (is_read_cmd) begin
						d.st = S_READ;
					end else if (wr_w && at_a) begin
						case (bus_wdata)
							`FCS_CMD_ID: d.st = S_ID;
							`FCS_CMD_PROG: d.st = S_PRG_TOP;
							`FCS_CMD_ERASE: d.st = S_E3;
							default: d.st = ret_st;
						endcase
					end
				end
			end
			S_PRG_TOP: begin
				// page top word: software reset no longer honoured
				if (wr_w) begin
					d.st = S_PRG_DATA;
					d.cnt = '0;
					d.skip = prot_vec[wr_blk];
					d.arr_start = !prot_vec[wr_blk];
					d.arr_wr = !prot_vec[wr_blk];
					d.arr_op = OP_PROG;
					d.arr_addr = bus_addr;
					d.arr_wdata = bus_wdata;
				end
			end
			S_PRG_DATA: begin
				if (wr_w) begin
					d.cnt = s_q.cnt + 1'b1;
					d.arr_wr = !s_q.skip;
					d.arr_addr = s_q.arr_addr + `FCS_WORD_STEP;
					d.arr_wdata = bus_wdata;
					if (s_q.cnt == CNT_LAST - 1'b1) begin
						d.st = s_q.skip ? S_READ : S_PRG_WAIT;
					end
				end
			end
			S_PRG_WAIT, S_ERS_WAIT: begin
				// bus writes ignored here
				if (arr_fail) begin
					d.st = S_LOCK;
				end else if (arr_done) begin
					d.st = S_READ;
				end
			end
			S_E5: begin
				if (bus_wr) begin
					d.st = ret_st;
					d.arr_addr = bus_addr;
					if (is_read_cmd) begin
						d.st = S_READ;
					end else if (wr_w && at_a
						&& bus_wdata == `FCS_CMD_CHIP) begin
						if (!(&prot_vec)) begin
							d.st = S_ERS_WAIT;
							d.arr_start = 1'b1;
							d.arr_op = OP_CHIP;
						end else begin
							d.st = S_READ;
						end
					end else if (wr_w && bus_wdata == `FCS_CMD_BLOCK) begin
						if (!prot_vec[wr_blk]) begin
							d.st = S_ERS_WAIT;
							d.arr_start = 1'b1;
							d.arr_op = OP_BLOCK;
						end else begin
							d.st = S_READ;
						end
					end else if (wr_w && bus_wdata[31:`FCS_PROT_LSB]
						== `FCS_CMD_PROT_HI) begin
						d.st = S_READ;
						d.prot_wr = 1'b1;
						d.prot_blk = wr_blk;
						d.prot_code = bus_wdata[`FCS_PROT_W-1:0];
					end
				end
			end
			S_LOCK: begin
				d.st = S_LOCK;
			end
			default: begin
				d.st = S_READ;
			end
		endcase
		// any entry begun from ID mode falls back to ID on a mismatching write
		d.in_id = d.st == S_ID
			|| (s_q.in_id && (d.st inside {S_C1, S_C2, S_E3, S_E4, S_E5}));
		d.rdy = !(d.st inside {S_PRG_DATA, S_PRG_WAIT,
			S_ERS_WAIT, S_LOCK});
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			s_q <= '0;
			s_q.rdy <= 1'b1;
		end else begin
			s_q <= d;
		end
	end

	assign rd_ack = s_q.rd_ack;
	assign rd_refused = s_q.rd_refused;
	assign rd_data = s_q.rd_data;
	assign arr_start = s_q.arr_start;
	assign arr_wr = s_q.arr_wr;
	assign arr_op = s_q.arr_op;
	assign arr_addr = s_q.arr_addr;
	assign arr_wdata = s_q.arr_wdata;
	assign arr_keep = prot_vec;
	assign ready_busy_flag = s_q.rdy;
	assign fetch_ok = s_q.rdy && s_q.st != S_ID;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (srst);

	sequence seq_rr_tail;
		s_q.st == S_C2 && is_read_cmd;
	endsequence

	sequence seq_page_end;
		s_q.st == S_PRG_DATA && wr_w && s_q.cnt == CNT_LAST - 1'b1;
	endsequence

	sequence seq_chip_cmd;
		s_q.st == S_E5 && wr_w && at_a && bus_wdata == `FCS_CMD_CHIP
			&& !(&prot_vec);
	endsequence

	AST_NO_ARRAY_READ_BUSY: assert property (
		!ready_busy_flag |-> !arr_rd_en && !fetch_ok
		##1 (!$past(rd_req) || (rd_refused && rd_data == '0)))
		else $error("array read while busy");
	AST_AUTO_HOLDS: assert property (
		s_q.st == S_ERS_WAIT && !arr_done && !arr_fail
		|=> s_q.st == S_ERS_WAIT && !ready_busy_flag)
		else $error("automatic operation left early");
	AST_DONE_TO_READ: assert property (
		s_q.st == S_PRG_WAIT && arr_done && !arr_fail
		|=> s_q.st == S_READ && ready_busy_flag)
		else $error("no read mode after completion");
	AST_READ_CMD: assert property (
		(s_q.st inside {S_READ, S_C1, S_E3, S_E4, S_E5}) && is_read_cmd
		|=> s_q.st == S_READ)
		else $error("read command not honoured");
	AST_RR_THIRD: assert property (
		seq_rr_tail |=> s_q.st == S_READ && !s_q.in_id)
		else $error("read/reset did not return to read mode");
	AST_MISMATCH: assert property (
		s_q.st == S_C1 && bus_wr && !wr_unlock2
		|=> s_q.st inside {S_READ, S_ID})
		else $error("mismatch did not abandon command");
	AST_CANCEL: assert property (
		s_q.st == S_E4 && is_read_cmd |=> s_q.st == S_READ)
		else $error("read/reset failed to cancel entry");
	AST_ID_STAYS: assert property (
		(s_q.st == S_ID && !bus_wr) [*2] |=> s_q.st == S_ID)
		else $error("ID mode left without command");
	AST_PROT_BLOCK: assert property (
		arr_start && arr_op == OP_BLOCK
		|-> !prot_vec[arr_addr[BLK_SHIFT +: BLK_W]])
		else $error("protected block erased");
	AST_CHIP_LAUNCH: assert property (
		seq_chip_cmd |=> arr_start && arr_op == OP_CHIP
		##1 !arr_start && !ready_busy_flag)
		else $error("chip erase not launched");
	AST_PAGE_END: assert property (
		seq_page_end |=> s_q.st inside {S_PRG_WAIT, S_READ})
		else $error("page not closed after last word");
	AST_BUSY_IGNORES: assert property (
		s_q.st == S_PRG_WAIT && bus_wr && !arr_done && !arr_fail
		|=> s_q.st == S_PRG_WAIT && !arr_start)
		else $error("command taken while busy");
	AST_FAIL_LOCK: assert property (
		(s_q.st inside {S_PRG_WAIT, S_ERS_WAIT}) && arr_fail
		|=> s_q.st == S_LOCK ##1 s_q.st == S_LOCK)
		else $error("failure did not lock");
	AST_RDY_LAUNCH: assert property (
		arr_start |-> !ready_busy_flag)
		else $error("ready flag high at launch");

endmodule

// >>> test/fcs_array_model.sv
// array-side model: operation timing and read data
`timescale 1ns/1ps

module fcs_array_model #(
	parameter int DLY = 20
) (
	input  wire logic        sys_clk,
	input  wire logic        srst,
	input  wire logic        arr_rd_en,
	input  wire logic [31:0] arr_rd_addr,
	output logic      [31:0] arr_rdata,
	input  wire logic        arr_start,
	output logic             arr_done,
	output logic             arr_fail,
	input  wire logic        fail_mode
);
	int cnt;

	// unread bus shows the address itself, read its inverse, never stale data
	assign arr_rdata = arr_rd_en ? ~arr_rd_addr : arr_rd_addr;

	always @(posedge sys_clk) begin
		arr_done <= 1'b0;
		arr_fail <= 1'b0;
		if (srst) begin
			cnt <= 0;
		end else if (arr_start) begin
			cnt <= DLY;
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
			if (cnt == 1) begin
				arr_done <= !fail_mode;
				arr_fail <= fail_mode;
			end
		end
	end
endmodule

// >>> test/test_flash_command_sequencer.sv
// self-checking bench for the flash command sequencer
`timescale 1ns/1ps

module test_flash_command_sequencer import fcs_pkg::*;;
	localparam logic [31:0] ID_V = 32'h0000_1234; // arbitrary value
	logic        sys_clk = 1'b0;
	logic        srst = 1'b1;
	logic        bus_wr = 1'b0;
	logic        bus_wr_word = 1'b0;
	logic        rd_req = 1'b0;
	logic        fail_mode = 1'b0;
	logic [31:0] bus_addr = 32'h0;
	logic [31:0] bus_wdata = 32'h0;
	logic [31:0] rd_addr = 32'h0;
	logic [31:0] arr_rdata, arr_rd_addr, rd_data, arr_addr, arr_wdata;
	logic        rd_ack, rd_refused, arr_rd_en, arr_start, arr_wr;
	logic        arr_done, arr_fail, ready_busy_flag, fetch_ok;
	fcs_op_t     arr_op;
	logic [15:0] arr_keep;
	int          bad_count = 0;
	int          n_tests = 0;

	always #5 sys_clk = ~sys_clk;

	fcs_sequencer #(.PAGE_WORDS(4), .DEV_ID(ID_V)) fcs_sequencer_i (
		.sys_clk, .srst, .bus_wr, .bus_wr_word, .bus_addr, .bus_wdata,
		.rd_req, .rd_addr, .rd_ack, .rd_refused, .rd_data, .arr_rd_en,
		.arr_rd_addr, .arr_rdata, .arr_start, .arr_wr, .arr_op,
		.arr_addr, .arr_wdata, .arr_keep, .arr_done, .arr_fail,
		.ready_busy_flag, .fetch_ok
	);

	fcs_array_model fcs_array_model_i (
		.sys_clk, .srst, .arr_rd_en, .arr_rd_addr, .arr_rdata,
		.arr_start, .arr_done, .arr_fail, .fail_mode
	);

	task automatic end_of_test;
		if (bad_count == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, g);
		n_tests++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// one word or narrow write per cycle, strobe left up for the next
	task automatic wr(input logic [31:0] a, d, input logic w = 1'b1);
		bus_wr = 1'b1;
		bus_wr_word = w;
		bus_addr = a;
		bus_wdata = d;
		@(negedge sys_clk);
	endtask

	task automatic idle(input int n);
		bus_wr = 1'b0;
		repeat (n) @(negedge sys_clk);
	endtask

	task automatic ul(input logic [31:0] cmd, input logic w = 1'b1);
		// no fetch or other access between the command writes
		wr(32'h5400, 32'haa, w);
		wr(32'haa00, 32'h55, w);
		wr(32'h5400, cmd, w);
	endtask

	task automatic rd(input logic [31:0] a, e, input logic rf);
		rd_req = 1'b1;
		rd_addr = a;
		@(negedge sys_clk);
		rd_req = 1'b0;
		chk("rd_ack", 1, rd_ack);
		chk("rd_refused", rf, rd_refused);
		chk("rd_data", e, rd_data);
		@(negedge sys_clk);
	endtask

	task automatic wait_rdy;
		int i;
		for (i = 0; i < 100 && ready_busy_flag !== 1'b1; i++)
			@(negedge sys_clk);
		chk("ready", 1, ready_busy_flag);
	endtask

	task automatic er(input logic [31:0] a, d);
		ul(32'h80);
		wr(32'h5400, 32'haa);
		wr(32'haa00, 32'h55);
		wr(a, d);
	endtask

	task automatic t_reset;
		chk("ready", 1, ready_busy_flag);
		chk("fetch_ok", 1, fetch_ok);
		rd(32'h100, ~32'h100, 1'b0);
	endtask

	task automatic t_prog(input logic [31:0] top, input logic prot);
		ul(32'ha0);
		wr(top, 32'h1111_0000);
		chk("arr_start", !prot, arr_start);
		chk("busy", 0, ready_busy_flag);
		chk("arr_op", OP_PROG, arr_op);
		wr(top + 32'h4, 32'h1111_0001);
		wr(top + 32'h8, 32'h1111_0002);
		wr(top + 32'hc, 32'h1111_0003);
		chk("arr_wr", !prot, arr_wr);
		if (!prot) begin
			chk("arr_addr", top + 32'hc, arr_addr);
			chk("arr_wdata", 32'h1111_0003, arr_wdata);
		end
		wr(32'h0, 32'hf0);
		idle(1);
		if (!prot) begin
			chk("fetch_ok", 0, fetch_ok);
			rd(32'h0, 32'h0, 1'b1);
		end
		wait_rdy();
		rd(top, ~top, 1'b0);
	endtask

	task automatic t_abort;
		wr(32'h5400, 32'haa);
		wr(32'haa00, 32'h66);
		ul(32'h90);
		idle(3);
		rd(32'h40, ID_V, 1'b0);
		wr(32'h5400, 32'haa);
		wr(32'h8, 32'hf0);
		idle(1);
		rd(32'h40, ~32'h40, 1'b0);
		ul(32'h90);
		ul(32'hf0);
		idle(1);
		rd(32'h44, ~32'h44, 1'b0);
		ul(32'h90, 1'b0);
		idle(1);
		rd(32'h48, ~32'h48, 1'b0);
		ul(32'h80);
		wr(32'h5400, 32'haa);
		wr(32'h0, 32'hf0);
		idle(1);
		rd(32'h4c, ~32'h4c, 1'b0);
	endtask

	task automatic t_erase;
		er(32'h0003_0000, 32'h63);
		idle(2);
		chk("arr_keep", 1, arr_keep[3]);
		er(32'h0003_0000, 32'h30);
		chk("arr_start", 0, arr_start);
		idle(1);
		chk("ready", 1, ready_busy_flag);
		t_prog(32'h0003_0100, 1'b1);
		er(32'h0005_0000, 32'h30);
		chk("arr_start", 1, arr_start);
		chk("arr_op", OP_BLOCK, arr_op);
		chk("arr_addr", 32'h0005_0000, arr_addr);
		idle(1);
		wait_rdy();
		fail_mode = 1'b1;
		er(32'h5400, 32'h10);
		chk("arr_start", 1, arr_start);
		chk("arr_op", OP_CHIP, arr_op);
		idle(30);
		chk("locked", 0, ready_busy_flag);
		wr(32'h0, 32'hf0);
		idle(2);
		chk("locked", 0, ready_busy_flag);
		rd(32'h0, 32'h0, 1'b1);
		srst = 1'b1;
		fail_mode = 1'b0;
		repeat (2) @(negedge sys_clk);
		srst = 1'b0;
		@(negedge sys_clk);
		chk("ready", 1, ready_busy_flag);
		chk("arr_keep", 0, arr_keep);
		rd(32'h80, ~32'h80, 1'b0);
	endtask

	initial begin
		repeat (5000) @(posedge sys_clk);
		bad_count++;
		end_of_test();
	end

	initial begin
		repeat (6) @(negedge sys_clk);
		srst = 1'b0;
		@(negedge sys_clk);
		t_reset();
		t_prog(32'h0002_0000, 1'b0);
		t_abort();
		t_erase();
		end_of_test();
	end
endmodule
